// ==== logic/nsl_led_driver.v ====
// network status indicator driver with two display modes
`timescale 1ns/10ps
`default_nettype none
`include "nsl_led_map.vh"
module nsl_led_driver #(
  parameter integer CLK_HZ = `NSL_REF_CLK_HZ
) (
  input wire phy_ref_clock_in,
  input wire rst_n,
  input wire display_mode,
  input wire link_good,
  input wire speed_100,
  input wire full_duplex,
  input wire activity,
  input wire collision,
  input wire aux_power_sense,
  input wire main_power_sense,
  output reg link_activity_indicator,
  output reg line_rate_indicator,
  output reg duplex_collision_indicator,
  output reg aux_power_present,
  output reg host_power_present
);
  // width large enough to hold a count
  function integer nsl_bits;
    input integer value;
    integer rest;
    begin
      nsl_bits = 1;
      rest = value;
      while (rest > 1) begin
        nsl_bits = nsl_bits + 1;
        rest = rest >> 1;
      end
    end
  endfunction

  // half period counts for each blink rate
  localparam integer ACT_HALF = CLK_HZ / (2 * `NSL_ACT_BLINK_HZ);
  localparam integer COL_HALF = CLK_HZ / (2 * `NSL_COL_BLINK_HZ);
  localparam integer MAX_HALF = (ACT_HALF > COL_HALF) ? ACT_HALF : COL_HALF;
  // counter sized from the clock rate, not fixed
  localparam integer CW = nsl_bits(MAX_HALF);
  localparam integer N_BLINK = `NSL_BLINK_CHANNELS;
  localparam integer SD = `NSL_SYNC_DEPTH;
  // counter step at counter width
  localparam [CW-1:0] ONE = {{(CW-1){1'h0}}, 1'h1};

  // mode decode shared by all three lamps
  function first_mode;
    input mode;
    begin
      first_mode = (mode == `NSL_MODE_FIRST);
    end
  endfunction

  // last two stages agree, so the level is settled
  function settled;
    input [SD-1:0] chain;
    begin
      settled = (chain[SD-2] == chain[SD-1]);
    end
  endfunction

  // phase of each blink channel, activity first
  wire [N_BLINK-1:0] blink_phase;
  wire act_phase;
  wire col_phase;

  reg [SD-1:0] aux_sync_ff;
  reg [SD-1:0] main_sync_ff;
  // next lamp values
  reg nxt_lk;
  reg nxt_rate;
  reg nxt_dc;
  genvar gi;

  // free running blink phase generators, both start dark
  generate
    for (gi = 0; gi < N_BLINK; gi = gi + 1) begin : g_blink
      // each channel picks its own half period
      localparam integer HALF = (gi == `NSL_BLINK_ACT) ? ACT_HALF : COL_HALF;
      localparam integer LAST_I = HALF - 1;
      localparam [CW-1:0] LAST = LAST_I[CW-1:0];
      reg [CW-1:0] cnt_ff;
      reg phase_ff;

      // counters run whatever the inputs show, so each blink channel keeps its own steady rhythm
      always @(posedge phy_ref_clock_in or negedge rst_n) begin
        if (!rst_n) begin
          cnt_ff <= {CW{1'h0}};
          phase_ff <= `NSL_LED_OFF;
        end else if (cnt_ff == LAST) begin
          // wrap at the last count of the half period
          cnt_ff <= {CW{1'h0}};
          phase_ff <= ~phase_ff;
        end else begin
          cnt_ff <= cnt_ff + ONE;
        end
      end

      assign blink_phase[gi] = phase_ff;
    end
  endgenerate

  assign act_phase = blink_phase[`NSL_BLINK_ACT];
  assign col_phase = blink_phase[`NSL_BLINK_COL];

  // activity blink wins over the steady link lamp
  always @* begin
    if (activity) begin
      nxt_lk = act_phase;
    end else if (first_mode(display_mode) && link_good) begin
      nxt_lk = `NSL_LED_ON;
    end else begin
      // second mode: this lamp shows traffic only
      nxt_lk = `NSL_LED_OFF;
    end
  end

  // speed lamp ignores link in the first mode
  always @* begin
    if (first_mode(display_mode)) begin
      nxt_rate = speed_100;
    end else begin
      nxt_rate = link_good & speed_100;
    end
  end

  // second mode reuses this lamp for a slow link
  always @* begin
    if (first_mode(display_mode)) begin
      if (full_duplex) begin
        nxt_dc = `NSL_LED_ON;
      end else if (collision) begin
        nxt_dc = col_phase;
      end else begin
        nxt_dc = `NSL_LED_OFF;
      end
    end else begin
      nxt_dc = link_good & ~speed_100;
    end
  end

  // every lamp leaves a flip-flop, so no glitch reaches a pin
  always @(posedge phy_ref_clock_in or negedge rst_n) begin
    if (!rst_n) begin
      link_activity_indicator <= `NSL_LED_OFF;
    end else begin
      link_activity_indicator <= nxt_lk;
    end
  end

  always @(posedge phy_ref_clock_in or negedge rst_n) begin
    if (!rst_n) begin
      line_rate_indicator <= `NSL_LED_OFF;
    end else begin
      line_rate_indicator <= nxt_rate;
    end
  end

  always @(posedge phy_ref_clock_in or negedge rst_n) begin
    if (!rst_n) begin
      duplex_collision_indicator <= `NSL_LED_OFF;
    end else begin
      duplex_collision_indicator <= nxt_dc;
    end
  end

  // three stage synchronisers on the power sense pins
  // the first stage may go metastable; only the shift reads it
  always @(posedge phy_ref_clock_in or negedge rst_n) begin
    if (!rst_n) begin
      aux_sync_ff <= {SD{1'h0}};
    end else begin
      aux_sync_ff <= {aux_sync_ff[SD-2:0], aux_power_sense};
    end
  end

  always @(posedge phy_ref_clock_in or negedge rst_n) begin
    if (!rst_n) begin
      main_sync_ff <= {SD{1'h0}};
    end else begin
      main_sync_ff <= {main_sync_ff[SD-2:0], main_power_sense};
    end
  end

  // a sense level counts once the last two stages agree
  always @(posedge phy_ref_clock_in or negedge rst_n) begin
    if (!rst_n) begin
      aux_power_present <= 1'h0;
    end else if (settled(aux_sync_ff)) begin
      aux_power_present <= aux_sync_ff[SD-1];
    end
  end

  // host bus power sense, same treatment
  always @(posedge phy_ref_clock_in or negedge rst_n) begin
    if (!rst_n) begin
      host_power_present <= 1'h0;
    end else if (settled(main_sync_ff)) begin
      host_power_present <= main_sync_ff[SD-1];
    end
  end
endmodule // nsl_led_driver
`default_nettype wire

// ==== include/nsl_led_map.vh ====
// constants for the network status indicator driver
`ifndef NSL_LED_MAP_VH
`define NSL_LED_MAP_VH
`define NSL_REF_CLK_HZ 25000000
`define NSL_ACT_BLINK_HZ 10
`define NSL_COL_BLINK_HZ 20
`define NSL_MODE_FIRST 1'h0
`define NSL_MODE_SECOND 1'h1
`define NSL_LED_OFF 1'h0
`define NSL_LED_ON 1'h1
`define NSL_BLINK_CHANNELS 2
`define NSL_BLINK_ACT 0
`define NSL_BLINK_COL 1
`define NSL_SYNC_DEPTH 3
`endif

// ==== tb/nsl_lamp_model.sv ====
// lamp model timing each lit stretch
`timescale 1ns/10ps
`default_nettype none
module nsl_lamp_model(input wire clk, lamp, output var int last_on);
  int run=0;
  always @(posedge clk) run<=lamp ? run+1 : 0;
  always @(posedge clk) if (!lamp && run>0) last_on<=run;
endmodule // nsl_lamp_model
`default_nettype wire

// ==== tb/nsl_led_checker.sv ====
// indicator driver checker
`timescale 1ns/10ps
`default_nettype none
module nsl_led_checker(input wire phy_ref_clock_in, rst_n, display_mode, link_good, speed_100, full_duplex,
  activity, collision, link_activity_indicator, line_rate_indicator, duplex_collision_indicator);
  wire m=display_mode, a=activity, k=link_good, s=speed_100, l=link_activity_indicator;
  wire r=line_rate_indicator, d=duplex_collision_indicator;
  default clocking @(posedge phy_ref_clock_in); endclocking
  default disable iff (!rst_n);
  rate_one_a: assert property (!m |=> r==$past(s)) else $error("rate");
  fast_link_a: assert property (m |=> r==$past(k&s)) else $error("fast");
  slow_link_a: assert property (m |=> d==$past(k&!s)) else $error("slow");
  full_dup_a: assert property (!m && full_duplex |=> d) else $error("full");
  dup_dark_a: assert property (!m && !full_duplex && !collision |=> !d) else $error("dark");
  link_on_a: assert property (!m && k && !a |=> l) else $error("link");
  act_idle_a: assert property (m && !a |=> !l) else $error("idle");
  blink_hold_a: assert property ($rose(l) && a && $past(a) && $past(a, 2) ##1 a[*8] |-> l) else $error("blink");
  cover property (m && a && l);
  cover property (!m && collision && d);
  cover property (m && r);
endmodule // nsl_led_checker
bind nsl_led_driver nsl_led_checker i_nsl_led_checker(.*);
`default_nettype wire

// ==== tb/tb_nsl_led_driver.sv ====
// indicator driver bench
`timescale 1ns/10ps
`default_nettype none
module tb_nsl_led_driver;
  logic clk=0, rst_n=0, m=0, k=0, s=0, f=0, a=0, c=0, p=0, q=0, la, r, d, ap, hp;
  int miscompares=0, n_tests=0, seed=32'h28F0, cyc=0, t;
  nsl_led_driver #(.CLK_HZ(400)) i_nsl_led_driver(.phy_ref_clock_in(clk), .rst_n, .display_mode(m), .link_good(k),
    .speed_100(s), .full_duplex(f), .activity(a), .collision(c), .aux_power_sense(p), .main_power_sense(q),
    .link_activity_indicator(la), .line_rate_indicator(r), .duplex_collision_indicator(d), .aux_power_present(ap),
    .host_power_present(hp));
  nsl_lamp_model i_nsl_lamp_model(.clk, .lamp(m ? la : d), .last_on(t));
  task chk(input logic [31:0] g, e);
    n_tests++;
    miscompares+=int'(g!==e);
    if (g!==e) $display("[FAIL] %0t %h %h", $time, g, e);
  endtask
  function logic [2:0] exp_leds(input logic em, ek, es, ef);
    return {!em && ek, em ? ek && es : es, em ? ek && !es : ef};
  endfunction
  task stop_test(input int x);
    miscompares+=x;
    $display("%0d checks %0d fails", n_tests, miscompares);
    if (!miscompares && n_tests) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial forever #5 clk=~clk;
  always @(posedge clk) if (++cyc>999) stop_test(1);
  initial begin
    repeat (20) @(negedge clk);
    chk({la, r, d, ap, hp}, 32'h0);
    rst_n=1;
    repeat (200) begin
      {m, k, s, f}=4'($random(seed));
      @(negedge clk);
      chk({la, r, d}, exp_leds(m, k, s, f));
    end
    {m, a, c, f, p}=5'h1D;
    repeat (80) @(negedge clk);
    chk(t, 32'h14);
    chk({ap, hp}, 32'h2);
    m=0;
    q=1;
    repeat (80) @(negedge clk);
    chk(t, 32'hA);
    chk({ap, hp}, 32'h3);
    stop_test(0);
  end
endmodule // tb_nsl_led_driver
`default_nettype wire
